// ==== sfsp_fifo.sv ====
// file: small valid/ready fifo for received write bytes
`timescale 1ns/10ps
`default_nettype none
module sfsp_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;
  assign o_ready = (cnt_q != (PW+1)'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign o_data = mem_q[rd_q];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_data;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : sfsp_fifo
`default_nettype wire

// ==== sfsp_master_model.sv ====
// file: serial bus master model driving the slave port pins
`timescale 1ns/10ps
`default_nettype none
module sfsp_master_model (
  input wire logic i_clk,
  input wire logic i_so,
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  output logic o_pause_n,
  output logic o_guard_n
);
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    o_pause_n = 1'b1;
    o_guard_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  task automatic guard(input logic g);
    o_guard_n <= g;
  endtask : guard
  task automatic start(input logic m3);
    o_sck <= m3;
    tick(4);
    o_cs_n <= 1'b0;
    tick(4);
  endtask : start
  // nb below 8 cuts the byte short; ph pauses before that bit
  task automatic xfer(input logic [7:0] b, input int nb, input int ph, output logic [7:0] r);
    for (int i = 0; i < nb; i++) begin
      o_sck <= 1'b0;
      o_si <= b[7 - i];
      tick(2);
      if (i == ph) begin
        o_pause_n <= 1'b0;
        tick(20);
        o_pause_n <= 1'b1;
        tick(6); // resumed output needs the pause pin through its sync first
      end
      tick(2);
      o_sck <= 1'b1;
      tick(3);
      r[7 - i] = i_so; // late, so the fall-edge update has landed
      tick(1);
    end
    tick(6);
  endtask : xfer
  task automatic stop(input logic m3);
    o_sck <= m3;
    tick(4);
    o_cs_n <= 1'b1;
    o_si <= ~o_si; // released line must not keep its last value
    tick(8);
  endtask : stop
endmodule : sfsp_master_model
`default_nettype wire

// ==== sfsp_pkg.sv ====
// package: constants for the serial byte-memory slave port
package sfsp_pkg;
  localparam int ADDR_W = 15;
  localparam int MEM_DEPTH = 32768;
  localparam int FIFO_DEPTH = 4;
  localparam int SYNC_STAGES = 3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FSTRD = 8'h0B;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_RDID = 8'h9F;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam int GUARD_BIT = 7;
  localparam int BP_HI = 3;
  localparam int BP_LO = 2;
  localparam int WEL_BIT = 1;
  localparam int ID_BYTES = 9;
  typedef enum logic [6:0] {
    SF_IDLE = 7'h01, SF_OPC = 7'h02, SF_ADDR = 7'h04, SF_WDATA = 7'h08,
    SF_RDATA = 7'h10, SF_WSTAT = 7'h20, SF_DROP = 7'h40
  } sfsp_state_type;
endpackage : sfsp_pkg

// ==== sfsp_port.sv ====
// file: serial slave port of a 32K x 8 nonvolatile byte memory
// Behaviour
// R1 - inputs sampled on serial clock rise, output changes on its fall
// R2 - any serial clock rate to 40 MHz; clock may stop anytime
// R3 - chip select high: idle, inputs ignored, output released
// R4 - master gives fresh chip select fall before every opcode
// R5 - output driven only while returning read data, never during pause
// R6 - guard pin low with guard enable set blocks status writes
// R7 - pause low suspends transaction, ignoring clock and select edges
// R8 - master changes pause only while serial clock low
// R9 - each data byte committed right after its eighth bit
// R10 - 32K byte locations, each uniquely addressed
// R11 - clock modes 0 and 3 accepted only
// R12 - read-only identification value available to master
// R13 - quarter, half, whole array protection plus write disable
// R14 - all fields travel most significant bit first
// R15 - two-byte address, top bit ignored, low 15 bits used
// R16 - unknown opcode: drop input until next select fall, output released
// R17 - clock level at select fall picks mode 0 or mode 3
// R18 - partial data byte at select rise is discarded
`timescale 1ns/10ps
`default_nettype none
module sfsp_port #(
  parameter int DEPTH = sfsp_pkg::MEM_DEPTH,
  parameter logic [7:0] ID_MAKER = 8'h5A, // arbitrary value
  parameter logic [7:0] ID_PART = 8'h21,  // arbitrary value
  parameter logic [7:0] ID_REV = 8'h03    // arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_guard_n,
  input wire logic i_pause_n,
  output logic o_so,
  output logic o_so_oe,
  output logic o_mode3
);
  localparam int AW = sfsp_pkg::ADDR_W;
  // three-stage sync; a change counts once stages two and three agree
  logic [2:0] sck_s_q, cs_s_q, si_s_q, gd_s_q, ps_s_q;
  logic sck_q, cs_n_q, si_q, guard_n_q, pause_n_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sck_s_q <= 3'h0;
      cs_s_q <= 3'h7;
      si_s_q <= 3'h0;
      gd_s_q <= 3'h7;
      ps_s_q <= 3'h7;
    end else begin
      sck_s_q <= {sck_s_q[1:0], i_sck};
      cs_s_q <= {cs_s_q[1:0], i_cs_n};
      si_s_q <= {si_s_q[1:0], i_si};
      gd_s_q <= {gd_s_q[1:0], i_guard_n};
      ps_s_q <= {ps_s_q[1:0], i_pause_n};
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      si_q <= 1'b0;
      guard_n_q <= 1'b1;
      pause_n_q <= 1'b1;
    end else begin
      if (sck_s_q[1] == sck_s_q[2]) sck_q <= sck_s_q[2];
      if (cs_s_q[1] == cs_s_q[2]) cs_n_q <= cs_s_q[2];
      if (si_s_q[1] == si_s_q[2]) si_q <= si_s_q[2];
      if (gd_s_q[1] == gd_s_q[2]) guard_n_q <= gd_s_q[2];
      if (ps_s_q[1] == ps_s_q[2]) pause_n_q <= ps_s_q[2];
    end
  end
  // edges seen only while not paused; link clock must stay well below i_clk/8
  logic sck_p_q, cs_p_q;
  logic rise, fall, cs_fall, cs_rise;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sck_p_q <= 1'b0;
      cs_p_q <= 1'b1;
    end else if (pause_n_q) begin // see R7
      sck_p_q <= sck_q;
      cs_p_q <= cs_n_q;
    end
  end
  assign rise = pause_n_q && sck_q && !sck_p_q && !cs_n_q; // see R1 R2
  assign fall = pause_n_q && !sck_q && sck_p_q && !cs_n_q; // see R1
  assign cs_fall = pause_n_q && !cs_n_q && cs_p_q; // see R4
  assign cs_rise = pause_n_q && cs_n_q && !cs_p_q; // see R3
  sfsp_pkg::sfsp_state_type st_q;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic [7:0] op_q;
  logic [15:0] addr_q;
  logic abyte_q;
  logic [7:0] status_q;
  logic [7:0] tx_q;
  logic [3:0] id_q;
  logic mode3_q;
  logic [7:0] mem [DEPTH];
  logic [7:0] byte_in;
  logic byte_done;
  assign byte_in = {sh_q[6:0], si_q}; // see R14
  assign byte_done = rise && (bit_q == sfsp_pkg::BIT_LAST);
  // block protect: 01 upper quarter, 10 upper half, 11 whole array
  function automatic logic prot(input logic [1:0] bp, input logic [AW-1:0] a);
    case (bp)
      2'h1: prot = (a[AW-1:AW-2] == 2'h3);
      2'h2: prot = a[AW-1];
      2'h3: prot = 1'b1;
      default: prot = 1'b0;
    endcase
  endfunction : prot
  function automatic logic [7:0] id_byte(input logic [3:0] i);
    case (i)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: id_byte = 8'h7F;
      4'h6: id_byte = ID_MAKER;
      4'h7: id_byte = ID_PART;
      default: id_byte = ID_REV;
    endcase
  endfunction : id_byte
  // fifo decouples byte capture from array write; when full, that byte and the rest of the write are dropped
  logic f_in_ready, f_out_valid, f_wr_valid;
  logic [AW+7:0] f_out;
  assign f_wr_valid = byte_done && (st_q == sfsp_pkg::SF_WDATA) && status_q[sfsp_pkg::WEL_BIT]
                      && !prot(status_q[sfsp_pkg::BP_HI:sfsp_pkg::BP_LO], addr_q[AW-1:0]);
  sfsp_fifo #(.WIDTH(AW + 8), .DEPTH(sfsp_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(f_wr_valid),
    .o_ready(f_in_ready),
    .i_data({addr_q[AW-1:0], byte_in}),
    .o_valid(f_out_valid),
    .i_ready(1'b1),
    .o_data(f_out)
  );
  always_ff @(posedge i_clk) begin
    if (f_out_valid) begin
      mem[f_out[AW+7:8]] <= f_out[7:0]; // see R9 R10
    end
  end
  // bit counter and shifter; select rise drops any partial byte
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_q <= 3'h0;
      sh_q <= 8'h00;
    end else if (cs_fall || cs_rise) begin // see R18
      bit_q <= 3'h0;
      sh_q <= 8'h00;
    end else if (rise) begin // see R1
      bit_q <= bit_q + 3'h1;
      sh_q <= byte_in;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode3_q <= 1'b0;
    end else if (cs_fall) begin
      mode3_q <= sck_q; // see R17 R11
    end
  end
  assign o_mode3 = mode3_q;
  // command sequencer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= sfsp_pkg::SF_IDLE;
      op_q <= 8'h00;
      addr_q <= 16'h0000;
      abyte_q <= 1'b0;
      status_q <= sfsp_pkg::STATUS_RST;
      id_q <= 4'h0;
    end else if (cs_rise || (cs_n_q && cs_p_q)) begin // see R3 R7
      st_q <= sfsp_pkg::SF_IDLE;
    end else if (cs_fall) begin
      st_q <= sfsp_pkg::SF_OPC;
      abyte_q <= 1'b0;
      id_q <= 4'h0;
    end else if (byte_done) begin
      case (st_q)
        sfsp_pkg::SF_OPC: begin
          op_q <= byte_in;
          case (byte_in)
            sfsp_pkg::OP_WREN: begin
              status_q[sfsp_pkg::WEL_BIT] <= 1'b1;
              st_q <= sfsp_pkg::SF_DROP;
            end
            sfsp_pkg::OP_WRDI: begin
              status_q[sfsp_pkg::WEL_BIT] <= 1'b0; // see R13
              st_q <= sfsp_pkg::SF_DROP;
            end
            sfsp_pkg::OP_RDSR, sfsp_pkg::OP_RDID: st_q <= sfsp_pkg::SF_RDATA; // see R12
            sfsp_pkg::OP_WRSR: st_q <= sfsp_pkg::SF_WSTAT;
            sfsp_pkg::OP_READ, sfsp_pkg::OP_FSTRD, sfsp_pkg::OP_WRITE: begin
              st_q <= sfsp_pkg::SF_ADDR;
            end
            default: st_q <= sfsp_pkg::SF_DROP; // see R16
          endcase
        end
        sfsp_pkg::SF_ADDR: begin
          addr_q <= {addr_q[7:0], byte_in};
          abyte_q <= 1'b1;
          if (abyte_q) begin
            addr_q[15] <= 1'b0; // see R15
            st_q <= (op_q == sfsp_pkg::OP_WRITE) ? sfsp_pkg::SF_WDATA : sfsp_pkg::SF_RDATA;
          end
        end
        sfsp_pkg::SF_WDATA: begin
          addr_q[AW-1:0] <= addr_q[AW-1:0] + 1'b1;
          if (!f_in_ready) st_q <= sfsp_pkg::SF_DROP;
        end
        sfsp_pkg::SF_RDATA: begin
          if (op_q == sfsp_pkg::OP_RDID) begin
            if (id_q != 4'(sfsp_pkg::ID_BYTES - 1)) id_q <= id_q + 4'h1;
          end else if (op_q != sfsp_pkg::OP_RDSR) begin
            addr_q[AW-1:0] <= addr_q[AW-1:0] + 1'b1;
          end
        end
        sfsp_pkg::SF_WSTAT: begin
          if (status_q[sfsp_pkg::WEL_BIT] &&
              !(status_q[sfsp_pkg::GUARD_BIT] && !guard_n_q)) begin // see R6
            status_q[sfsp_pkg::GUARD_BIT] <= byte_in[sfsp_pkg::GUARD_BIT];
            status_q[sfsp_pkg::BP_HI:sfsp_pkg::BP_LO] <= byte_in[sfsp_pkg::BP_HI:sfsp_pkg::BP_LO];
          end
          status_q[sfsp_pkg::WEL_BIT] <= 1'b0;
          st_q <= sfsp_pkg::SF_DROP;
        end
        default: st_q <= st_q;
      endcase
    end
  end
  // read data loads on the first falling edge of each byte, shifts out on each later falling edge
  logic [7:0] rd_byte;
  always_comb begin
    case (op_q)
      sfsp_pkg::OP_RDSR: rd_byte = status_q;
      sfsp_pkg::OP_RDID: rd_byte = id_byte(id_q);
      default: rd_byte = mem[addr_q[AW-1:0]];
    endcase
  end
  logic ld_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_q <= 8'h00;
      ld_q <= 1'b0;
    end else if (st_q != sfsp_pkg::SF_RDATA) begin
      ld_q <= 1'b1;
    end else if (fall) begin // see R1 R14
      if (ld_q || bit_q == 3'h0) begin
        tx_q <= {rd_byte[6:0], 1'b0};
        ld_q <= 1'b0;
      end else begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end
  logic so_q, oe_q, drv_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      so_q <= 1'b0;
      oe_q <= 1'b0;
      drv_q <= 1'b0;
    end else begin
      if (fall && st_q == sfsp_pkg::SF_RDATA) begin
        so_q <= (ld_q || bit_q == 3'h0) ? rd_byte[7] : tx_q[7];
      end
      // drive state outlives a pause, so the pin comes back on resume
      drv_q <= (st_q == sfsp_pkg::SF_RDATA) && (drv_q || fall); // see R7
      oe_q <= (st_q == sfsp_pkg::SF_RDATA) && !cs_n_q && pause_n_q
              && (drv_q || fall); // see R5 R16
    end
  end
  assign o_so = so_q;
  assign o_so_oe = oe_q;
endmodule : sfsp_port
`default_nettype wire

// ==== sfsp_port_sva.sv ====
// file: concurrent checks on the serial slave port pins
`timescale 1ns/10ps
`default_nettype none
module sfsp_port_sva (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_guard_n,
  input wire logic i_pause_n,
  input wire logic o_so,
  input wire logic o_so_oe,
  input wire logic o_mode3
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  a_sel_idle_quiet: assert property (i_cs_n [*6] |-> !o_so_oe)
    else $error("output enabled while deselected");
  a_pause_quiet: assert property (!i_pause_n [*6] |-> !o_so_oe)
    else $error("output enabled during pause");
  a_oe_sel_drop: assert property ($rose(i_cs_n) |-> ##[1:6] !o_so_oe)
    else $error("output not released after deselect");
  a_oe_pause_drop: assert property ($fell(i_pause_n) |-> ##[1:6] !o_so_oe)
    else $error("output not released after pause");
  a_oe_rise_sel: assert property ($rose(o_so_oe) |-> !i_cs_n && i_pause_n)
    else $error("output enabled outside an active frame");
  a_so_steady_high: assert property ((o_so_oe && i_sck) [*8] |-> $stable(o_so))
    else $error("output changed with serial clock high");
  a_mode_three: assert property ($fell(i_cs_n) && i_sck && i_pause_n |-> ##8 o_mode3)
    else $error("mode 3 not picked");
  a_mode_zero: assert property ($fell(i_cs_n) && !i_sck && i_pause_n |-> ##8 !o_mode3)
    else $error("mode 0 not picked");
endmodule : sfsp_port_sva
bind sfsp_port sfsp_port_sva chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_sck(i_sck),
  .i_cs_n(i_cs_n), .i_si(i_si), .i_guard_n(i_guard_n), .i_pause_n(i_pause_n),
  .o_so(o_so), .o_so_oe(o_so_oe), .o_mode3(o_mode3));
`default_nettype wire

// ==== testbench.sv ====
// file: self-checking bench for the serial slave port
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
  $display("Error %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
  localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
  localparam logic [7:0] PART = 8'h44; // arbitrary value
  localparam logic [7:0] REV = 8'h17; // arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sck, cs_n, si, pause_n, guard_n, so, so_oe, mode3, oe_seen;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  logic prot_all = 1'b0;
  logic [31:0] seed = 32'h7525A167;
  logic [7:0] rq[$];
  logic [7:0] mem[int];
  always #20 clk = ~clk;
  sfsp_port #(.ID_MAKER(MAKER), .ID_PART(PART), .ID_REV(REV)) dut_u (.i_clk(clk),
    .i_rst(rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_guard_n(guard_n),
    .i_pause_n(pause_n), .o_so(so), .o_so_oe(so_oe), .o_mode3(mode3));
  sfsp_master_model m_u (.i_clk(clk), .i_so(so_oe ? so : ~so), .o_sck(sck),
    .o_cs_n(cs_n), .o_si(si), .o_pause_n(pause_n), .o_guard_n(guard_n));
  always @(posedge clk) if (so_oe === 1'b1) oe_seen <= 1'b1;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic run(input logic [7:0] q[$], input int nrd, input int lb, input int pb,
                     input logic m3);
    logic [7:0] r;
    rq = {};
    m_u.start(m3);
    foreach (q[k]) m_u.xfer(q[k], (k == q.size() - 1) ? lb : 8, -1, r);
    for (int k = 0; k < nrd; k++) begin
      m_u.xfer(8'h00, 8, (k == pb) ? 3 : -1, r);
      rq.push_back(r);
    end
    m_u.stop(m3);
    `CHK(mode3, m3)
  endtask : run
  // en low sends write-disable first, so nothing may land
  task automatic wr(input int a, input int n, input int lb, input logic en);
    logic [7:0] q[$];
    logic [31:0] t;
    q = '{8'h02, a[15:8], a[7:0]};
    for (int i = 0; i < n; i++) begin
      t = xs();
      q.push_back(t[7:0]);
      if (en && !prot_all && (i < n - 1 || lb == 8)) begin
        mem[(a + i) & 32'h7FFF] = t[7:0];
      end
    end
    run('{en ? 8'h06 : 8'h04}, 0, 8, -1, 1'b0);
    run(q, 0, lb, -1, 1'b0);
  endtask : wr
  task automatic rd(input int a, input int n, input int pb, input logic m3);
    run('{m3 ? 8'h0B : 8'h03, a[15:8], a[7:0]}, n, 8, pb, m3); // fast read in mode 3
    for (int i = 0; i < n; i++) `CHK(rq[i], mem[(a + i) & 32'h7FFF])
  endtask : rd
  task automatic st(input logic [7:0] v, input logic [7:0] mask, input logic [7:0] exp);
    run('{8'h06}, 0, 8, -1, 1'b0);
    run('{8'h01, v}, 0, 8, -1, 1'b0);
    run('{8'h05}, 1, 8, -1, 1'b0);
    `CHK(rq[0] & mask, exp)
  endtask : st
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    int a;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    run('{8'h9F}, 9, 8, -1, 1'b0);
    for (int i = 0; i < 9; i++)
      `CHK(rq[i], (i < 6) ? 8'h7F : (i == 6) ? MAKER : (i == 7) ? PART : REV)
    for (int m = 0; m < 2; m++) begin
      a = int'(xs() & 32'h3FF0);
      wr(a | 32'h8000, 4, 8, 1'b1); // top address bit ignored
      rd(a, 4, m + 1, m[0]);
      wr(a, 2, 8, 1'b0);
      wr(a + 1, 2, 4, 1'b1);
      rd(a, 3, -1, m[0]);
    end
    oe_seen = 1'b0;
    run('{8'hFF, 8'h03, 8'h00, 8'h00}, 2, 8, -1, 1'b0);
    `CHK(oe_seen, 1'b0)
    st(8'h80, 8'hFF, 8'h80);
    m_u.guard(1'b0);
    st(8'h00, 8'h80, 8'h80);
    m_u.guard(1'b1);
    st(8'h00, 8'hFF, 8'h00);
    prot_all = 1'b1;
    st(8'h0C, 8'hFF, 8'h0C);
    wr(a, 2, 8, 1'b1); // whole array guarded, nothing may land
    rd(a, 2, -1, 1'b0);
    prot_all = 1'b0;
    st(8'h00, 8'hFF, 8'h00);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
